// >>> rtl/crtg_pkg.sv
// Purpose: constants and carriers for the carrier receiver trip/guard logic
// Assumes: 20 MHz system clock
// Notes: all timer figures are in milliseconds
package crtg_pkg;
  localparam int unsigned CRTG_CLK_HZ = 20000000;
  localparam int unsigned CRTG_TICK_MS = 1;
  localparam int unsigned CRTG_TICK_CYC = CRTG_CLK_HZ / 1000 * CRTG_TICK_MS;
  localparam int unsigned CRTG_MSW = 11;
  localparam logic [10:0] CRTG_HOLD_A_MS = 11'h00a;
  localparam logic [10:0] CRTG_HOLD_B_MS = 11'h032;
  localparam logic [10:0] CRTG_HOLD_C_MS = 11'h064;
  localparam logic [10:0] CRTG_UB_A_MS = 11'h096;
  localparam logic [10:0] CRTG_UB_B_MS = 11'h12c;
  localparam logic [10:0] CRTG_UB_C_MS = 11'h1f4;
  localparam logic [10:0] CRTG_LL_A_MS = 11'h032;
  localparam logic [10:0] CRTG_LL_B_MS = 11'h04b;
  localparam logic [10:0] CRTG_LL_C_MS = 11'h064;
  localparam logic [10:0] CRTG_GBT_MS = 11'h078;
  localparam logic [10:0] CRTG_OVR_MS = 11'h3e8;
  localparam logic [10:0] CRTG_DTT_STEP_MS = 11'h002;

  typedef enum logic [1:0] {
    CRTG_GBT_OFF = 2'b00,
    CRTG_GBT_NO_OVR = 2'b01,
    CRTG_GBT_OVR = 2'b10,
    CRTG_GBT_UNUSED = 2'b11
  } crtg_gbt_e;

  typedef struct packed {
    logic [1:0] ub_guard_hold;
    logic [1:0] unblock_time;
    logic noise_block;
    crtg_gbt_e gbt;
    logic [1:0] low_level_delay;
    logic [3:0] dtt_delay;
    logic [1:0] dtt_trip_hold;
    logic [1:0] dtt_guard_hold;
    logic checkback_from_transfer_trip;
    logic alt_polarity;
    logic one_clamp_phase_compare;
  } crtg_cfg_s;

  typedef struct packed {
    logic ub_trip;
    logic ub_guard;
    logic dtt_trip;
    logic dtt_guard;
    logic low_level;
    logic noise;
    logic pc_high;
    logic pc_low;
  } crtg_ind_s;

  typedef struct packed {
    logic ub_trip;
    logic ub_guard;
    logic low_level;
    logic dtt_trip;
    logic dtt_guard;
    logic checkback_trip;
    logic trip_pos;
    logic trip_neg;
  } crtg_out_s;
endpackage : crtg_pkg

// >>> rtl/crtg_logic.sv
// Purpose: trip/guard qualification for a carrier teleprotection receiver
// Assumes: indications and settings synchronous to i_mclk, settings static
// Notes: all timers share one millisecond tick; counts saturate
`timescale 1ns/1ps

// Functional notes
// - unblock guard output stretched by off, 10, 50 or 100 ms.
// - loss of channel gives unblock trip for off, 150, 300, 500 ms.
// - noise-block setting lets noise suppress the loss-of-channel unblock window trip, not the received trip.
// - guard-before-trip without override needs 120 ms continuous prior guard.
// - with override, 120 ms guard waived after trip persists over 1000 ms.
// - with override, loss of channel allows trip without guard qualification.
// - guard-before-trip code: off, without override, with override, unused.
// - low-level delay of off, 50, 75, 100 ms delays unblock start and output.
// - transfer trip withheld until indication continuously present for the delay.
// - delay is 2/4/8/16 ms weights summed, all-clear gives 2 ms.
// - transfer trip output stretched by off, 10, 50 or 100 ms.
// - transfer guard output stretched by off, 10, 50 or 100 ms.
// - checkback trip follows unblock trip or transfer trip by selection.
// - normal polarity maps high frequency to trip negative, low to positive.
// - zero clamp: low level or noise forces both trip outputs low.
// - one clamp: low level forces both trip outputs high.
module crtg_logic
  import crtg_pkg::*;
#(
  parameter int unsigned TICK_CYC = CRTG_TICK_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire crtg_cfg_s i_cfg,
  input wire crtg_ind_s i_ind,
  output crtg_out_s o_out
);
  initial begin
    if (TICK_CYC < 1 || TICK_CYC > 65536) begin
      $error("crtg_logic: TICK_CYC out of range");
    end
  end

  typedef logic [CRTG_MSW-1:0] crtg_ms_t;

  typedef struct packed {
    logic [15:0] pre;
    crtg_ms_t ub_ghold;
    crtg_ms_t ll_cnt;
    crtg_ms_t ub_cnt;
    logic ub_armed;
    crtg_ms_t guard_cnt;
    crtg_ms_t trip_age;
    crtg_ms_t dtt_cnt;
    crtg_ms_t dtt_thold;
    crtg_ms_t dtt_ghold;
    crtg_out_s out;
  } crtg_state_s;

  crtg_state_s st_r;
  crtg_state_s st_nxt;

  function automatic crtg_ms_t hold_ms(input logic [1:0] sel);
    case (sel)
      2'b01: hold_ms = CRTG_HOLD_A_MS;
      2'b10: hold_ms = CRTG_HOLD_B_MS;
      2'b11: hold_ms = CRTG_HOLD_C_MS;
      default: hold_ms = '0;
    endcase
  endfunction : hold_ms

  function automatic crtg_ms_t sat_inc(input crtg_ms_t v);
    sat_inc = (v == '1) ? v : crtg_ms_t'(v + 1'b1);
  endfunction : sat_inc

  crtg_ms_t ub_len;
  crtg_ms_t ll_len;
  crtg_ms_t dtt_len;
  logic tick;
  logic loc_raw;
  logic loc;
  logic ll_out;
  logic gbt_ok;
  logic ub_trip;
  logic dtt_ok;
  logic pos_raw;
  logic neg_raw;

  assign tick = (st_r.pre == 16'(TICK_CYC - 1));

  always_comb begin
    case (i_cfg.unblock_time)
      2'b01: ub_len = CRTG_UB_A_MS;
      2'b10: ub_len = CRTG_UB_B_MS;
      2'b11: ub_len = CRTG_UB_C_MS;
      default: ub_len = '0;
    endcase
    case (i_cfg.low_level_delay)
      2'b01: ll_len = CRTG_LL_A_MS;
      2'b10: ll_len = CRTG_LL_B_MS;
      2'b11: ll_len = CRTG_LL_C_MS;
      default: ll_len = '0;
    endcase
    dtt_len = crtg_ms_t'(i_cfg.dtt_delay) * CRTG_DTT_STEP_MS;
    if (i_cfg.dtt_delay == 4'h0) begin
      dtt_len = CRTG_DTT_STEP_MS;
    end
  end

  // loss of channel: low level without guard
  assign loc_raw = i_ind.low_level & ~i_ind.ub_guard;
  assign ll_out = i_ind.low_level & (st_r.ll_cnt >= ll_len);
  assign loc = loc_raw & (st_r.ll_cnt >= ll_len);

  always_comb begin
    case (i_cfg.gbt)
      CRTG_GBT_NO_OVR: gbt_ok = (st_r.guard_cnt >= CRTG_GBT_MS);
      CRTG_GBT_OVR: gbt_ok = (st_r.guard_cnt >= CRTG_GBT_MS) |
        (st_r.trip_age > CRTG_OVR_MS) | loc;
      CRTG_GBT_OFF: gbt_ok = 1'b1;
      default: gbt_ok = 1'b1;
    endcase
  end

  assign ub_trip = (i_ind.ub_trip & gbt_ok) |
    (st_r.ub_armed & ~(i_cfg.noise_block & i_ind.noise));

  assign dtt_ok = i_ind.dtt_trip & (st_r.dtt_cnt >= dtt_len);

  assign pos_raw = i_cfg.alt_polarity ? i_ind.pc_high : i_ind.pc_low;
  assign neg_raw = i_cfg.alt_polarity ? i_ind.pc_low : i_ind.pc_high;

  always_comb begin
    st_nxt = st_r;
    st_nxt.pre = tick ? '0 : 16'(st_r.pre + 1'b1);
    if (tick) begin
      st_nxt.ll_cnt = i_ind.low_level ? sat_inc(st_r.ll_cnt) : '0;
      st_nxt.guard_cnt = i_ind.ub_guard ? sat_inc(st_r.guard_cnt) : '0;
      st_nxt.trip_age = i_ind.ub_trip ? sat_inc(st_r.trip_age) : '0;
      st_nxt.dtt_cnt = i_ind.dtt_trip ? sat_inc(st_r.dtt_cnt) : '0;
      if (st_r.ub_armed) begin
        st_nxt.ub_cnt = sat_inc(st_r.ub_cnt);
      end
      if (st_r.ub_ghold != '0) begin
        st_nxt.ub_ghold = crtg_ms_t'(st_r.ub_ghold - 1'b1);
      end
      if (st_r.dtt_thold != '0) begin
        st_nxt.dtt_thold = crtg_ms_t'(st_r.dtt_thold - 1'b1);
      end
      if (st_r.dtt_ghold != '0) begin
        st_nxt.dtt_ghold = crtg_ms_t'(st_r.dtt_ghold - 1'b1);
      end
    end
    // one unblock window per loss of channel
    if (!loc) begin
      st_nxt.ub_armed = 1'b0;
      st_nxt.ub_cnt = '0;
    end else if (ub_len != '0 && st_r.ub_cnt == '0 && !st_r.ub_armed) begin
      st_nxt.ub_armed = 1'b1;
    end else if (st_r.ub_armed && st_r.ub_cnt >= ub_len) begin
      st_nxt.ub_armed = 1'b0;
    end
    if (i_ind.ub_guard) begin
      st_nxt.ub_ghold = hold_ms(i_cfg.ub_guard_hold);
    end
    if (dtt_ok) begin
      st_nxt.dtt_thold = hold_ms(i_cfg.dtt_trip_hold);
    end
    if (i_ind.dtt_guard) begin
      st_nxt.dtt_ghold = hold_ms(i_cfg.dtt_guard_hold);
    end
    st_nxt.out.ub_trip = ub_trip;
    st_nxt.out.ub_guard = i_ind.ub_guard | (st_r.ub_ghold != '0);
    st_nxt.out.low_level = ll_out;
    st_nxt.out.dtt_trip = dtt_ok | (st_r.dtt_thold != '0);
    st_nxt.out.dtt_guard = i_ind.dtt_guard | (st_r.dtt_ghold != '0);
    st_nxt.out.checkback_trip = i_cfg.checkback_from_transfer_trip ?
      st_nxt.out.dtt_trip : ub_trip;
    if (i_cfg.one_clamp_phase_compare) begin
      st_nxt.out.trip_pos = pos_raw | i_ind.low_level;
      st_nxt.out.trip_neg = neg_raw | i_ind.low_level;
    end else begin
      st_nxt.out.trip_pos = pos_raw & ~(i_ind.low_level | i_ind.noise);
      st_nxt.out.trip_neg = neg_raw & ~(i_ind.low_level | i_ind.noise);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  assign o_out = st_r.out;
endmodule : crtg_logic

// >>> verification/crtg_logic_sva.sv
// Purpose: port assertions for crtg_logic
// Assumes: settings static, i_ce high
// Notes: outputs lag inputs by one edge
`timescale 1ns/1ps
module crtg_logic_sva
  import crtg_pkg::*;
#(
  parameter int unsigned TICK_CYC = 4
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire crtg_cfg_s i_cfg,
  input wire crtg_ind_s i_ind,
  input wire crtg_out_s o_out
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence g_drop; i_cfg.ub_guard_hold == 2'h1 && $fell(i_ind.ub_guard); endsequence
  sequence g_kept; o_out.ub_guard [*8]; endsequence
  g_hold_a: assert property (g_drop |=> g_kept) else $error("guard hold short");
  t_delay_a: assert property ($rose(o_out.dtt_trip) |-> $past(i_ind.dtt_trip, 3))
    else $error("transfer trip early");
  t_nohold_a: assert property (i_cfg.dtt_trip_hold == 2'h0 && $fell(i_ind.dtt_trip)
    |=> !o_out.dtt_trip) else $error("transfer trip stretched");
  cb_src_a: assert property (o_out.checkback_trip == (i_cfg.checkback_from_transfer_trip
    ? o_out.dtt_trip : o_out.ub_trip)) else $error("checkback source");
  pol_map_a: assert property (!i_cfg.alt_polarity && !$past(i_ind.low_level | i_ind.noise)
    |-> {o_out.trip_pos, o_out.trip_neg} == $past({i_ind.pc_low, i_ind.pc_high}))
    else $error("polarity map");
  zero_clamp_a: assert property (!i_cfg.one_clamp_phase_compare
    && $past(i_ind.low_level | i_ind.noise) |-> !o_out.trip_pos && !o_out.trip_neg)
    else $error("zero clamp");
  one_clamp_a: assert property (i_cfg.one_clamp_phase_compare && $past(i_ind.low_level)
    |-> o_out.trip_pos && o_out.trip_neg) else $error("one clamp");
  gbt_qual_a: assert property (i_cfg.gbt == CRTG_GBT_NO_OVR && i_cfg.unblock_time == 2'h0
    && $rose(o_out.ub_trip) |-> $past(i_ind.ub_guard)) else $error("trip without guard");
  rst_clr_a: assert property (disable iff (1'b0) !i_rst_n |-> o_out == '0)
    else $error("output during reset");
endmodule : crtg_logic_sva

// >>> verification/crtg_demod_model.sv
// Purpose: receiver front-end stand-in driving indications
// Assumes: bench commands levels
// Notes: one register stage, as a decoder output
`timescale 1ns/1ps
module crtg_demod_model
  import crtg_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire crtg_ind_s i_cmd,
  output crtg_ind_s o_ind
);
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ind <= '0;
    end else begin
      o_ind <= i_cmd;
    end
  end
endmodule : crtg_demod_model

// >>> verification/crtg_logic_tb.sv
// Purpose: self-checking bench for crtg_logic
// Assumes: tick of 4 cycles, so 1 ms is 4 cycles
// Notes: settings change only under reset
`timescale 1ns/1ps
module crtg_logic_tb;
  import crtg_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b1;
  logic i_ce = 1'b1;
  crtg_cfg_s cfg = '0;
  crtg_ind_s cmd = '0;
  crtg_ind_s ind;
  crtg_out_s o_out;
  int n_errors = 0;
  int num_checks = 0;
  int n;
  int ms_a[4] = '{0, 10, 50, 100};
  int ms_u[4] = '{0, 150, 300, 500};
  int ms_l[4] = '{0, 50, 75, 100};
  initial begin
    forever #25 i_mclk = ~i_mclk;
  end
  crtg_demod_model dm (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cmd(cmd), .o_ind(ind));
  crtg_logic #(.TICK_CYC(4)) uut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce),
    .i_cfg(cfg), .i_ind(ind), .o_out(o_out));
  task automatic wrap_up;
    if (n_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t level", $time);
    end
  endtask : chk_bit
  // timing slack covers one tick of prescaler phase
  task automatic chk_ms(input int got, input int ms);
    num_checks++;
    if (got < ms * 4 - 4 || got > ms * 4 + 8) begin
      n_errors++;
      $display("BAD %0t took %0d", $time, got);
    end
  endtask : chk_ms
  task automatic wait_out(input int b, input logic v);
    n = 0;
    do begin
      @(negedge i_mclk);
      n++;
      if (n > 2500) begin
        n_errors++;
        $display("BAD %0t timeout", $time);
        wrap_up();
      end
    end while (o_out[b] !== v);
  endtask : wait_out
  task automatic go(input crtg_ind_s v);
    @(posedge i_mclk);
    cmd <= v;
  endtask : go
  task automatic restart(input crtg_cfg_s c);
    @(posedge i_mclk);
    i_rst_n <= 1'b0;
    cmd <= '0;
    cfg <= c;
    repeat (2) @(posedge i_mclk);
    chk_bit(|o_out, 1'b0);
    i_rst_n <= 1'b1;
  endtask : restart
  task automatic t_phase;
    crtg_cfg_s c;
    crtg_ind_s v;
    logic [1:0] e;
    for (int m = 0; m < 4; m++) begin
      c = '0;
      c.alt_polarity = m[0];
      c.one_clamp_phase_compare = m[1];
      restart(c);
      for (int k = 0; k < 16; k++) begin
        v = '0;
        {v.low_level, v.noise, v.pc_high, v.pc_low} = k[3:0];
        go(v);
        repeat (3) @(negedge i_mclk);
        e = m[0] ? {v.pc_high, v.pc_low} : {v.pc_low, v.pc_high};
        if (m[1] && v.low_level) begin
          e = 2'h3;
        end
        if (!m[1] && (v.low_level || v.noise)) begin
          e = 2'h0;
        end
        chk_bit(o_out.trip_pos, e[1]);
        chk_bit(o_out.trip_neg, e[0]);
      end
    end
  endtask : t_phase
  task automatic t_trip;
    crtg_cfg_s c;
    logic [3:0] code[4] = '{4'h0, 4'h1, 4'h7, 4'hf};
    for (int i = 0; i < 4; i++) begin
      c = '0;
      c.dtt_delay = code[i];
      c.dtt_trip_hold = i[1:0];
      c.checkback_from_transfer_trip = i[0];
      restart(c);
      go(8'h20);
      wait_out(4, 1'b1);
      chk_ms(n, (code[i] == 4'h0) ? 2 : 2 * code[i]);
      chk_bit(o_out.checkback_trip, i[0]);
      go(8'h00);
      wait_out(4, 1'b0);
      chk_ms(n, ms_a[i]);
      c.ub_guard_hold = i[1:0];
      c.dtt_guard_hold = i[1:0];
      restart(c);
      go(8'h50);
      repeat (8) @(negedge i_mclk);
      // transfer guard kept so each hold is timed on its own
      go(8'h10);
      wait_out(6, 1'b0);
      chk_ms(n, ms_a[i]);
      go(8'h00);
      wait_out(3, 1'b0);
      chk_ms(n, ms_a[i]);
    end
  endtask : t_trip
  task automatic t_unblock;
    crtg_cfg_s c;
    // unblock time and low-level delay stepped through all codes, then 150 ms with noise, noise block on then off
    for (int i = 0; i < 6; i++) begin
      c = '0;
      c.unblock_time = (i < 4) ? i[1:0] : 2'h1;
      c.low_level_delay = (i < 4) ? i[1:0] : 2'h0;
      c.noise_block = (i == 4);
      restart(c);
      go((i < 4) ? 8'h08 : 8'h0c);
      wait_out(5, 1'b1);
      chk_ms(n, ms_l[c.low_level_delay]);
      repeat (8) @(negedge i_mclk);
      chk_bit(o_out.ub_trip, i != 0 && i != 4);
      if (i != 0 && i != 4) begin
        wait_out(7, 1'b0);
        chk_ms(n + 8, ms_u[c.unblock_time]);
      end
    end
  endtask : t_unblock
  task automatic t_gbt;
    crtg_cfg_s c;
    for (int g = 0; g < 4; g++) begin
      c = '0;
      c.gbt = crtg_gbt_e'(g);
      restart(c);
      go(8'h80);
      repeat (40) @(negedge i_mclk);
      chk_bit(o_out.ub_trip, g == 0 || g == 3);
      repeat (4000) @(negedge i_mclk);
      chk_bit(o_out.ub_trip, g != 1);
      go(8'h40);
      repeat (500) @(negedge i_mclk);
      go(8'hc0);
      repeat (8) @(negedge i_mclk);
      chk_bit(o_out.ub_trip, 1'b1);
    end
    // loss of channel with trip, no guard ever seen
    for (int g = 1; g < 3; g++) begin
      c = '0;
      c.gbt = crtg_gbt_e'(g);
      restart(c);
      go(8'h88);
      repeat (8) @(negedge i_mclk);
      chk_bit(o_out.ub_trip, g == 2);
    end
  endtask : t_gbt
  task automatic t_freeze;
    restart('0);
    go(8'h20);
    @(posedge i_mclk);
    i_ce <= 1'b0;
    repeat (200) @(negedge i_mclk);
    chk_bit(o_out.dtt_trip, 1'b0);
    @(posedge i_mclk);
    i_ce <= 1'b1;
    wait_out(4, 1'b1);
    chk_ms(n, 2);
  endtask : t_freeze
  initial begin
    i_rst_n <= 1'b0;
    t_phase();
    t_trip();
    t_unblock();
    t_gbt();
    t_freeze();
    wrap_up();
  end
endmodule : crtg_logic_tb
bind crtg_logic crtg_logic_sva #(.TICK_CYC(TICK_CYC)) chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
  .i_ce(i_ce), .i_cfg(i_cfg), .i_ind(i_ind), .o_out(o_out));
